// file: tai_pkg.sv
// Package with register map, field positions and reset values for the target address block.
// Operation
// R01 - A 10-bit target-address field at bits 9 to 0 holds the address of the device to be addressed.
// R02 - The address is right-justified so its least significant bit sits at bit 0.
// R03 - The target address is used only in master operation and ignored in target operation.
// R04 - In 7-bit addressing bit 6 is the most significant bit and bits 9 to 7 are ignored.
// R05 - In 10-bit addressing bit 9 is the most significant bit and all ten bits are used.
// R06 - Event enables sit at bit 3 nack, bit 2 stop, bit 1 start, bit 0 arbitration lost, reset 0.
// R07 - Each instance has a receive enable at bit 2 and a transmit enable at bit 3, reset disabled.
// R08 - The transmit flag resets to 1 and sets on empty buffer, receive sets on a full character.
package tai_pkg;

  localparam logic [11:0] TAI_OFS_TADDR  = 12'h000;
  localparam logic [11:0] TAI_OFS_EVT_IE = 12'h004;
  localparam logic [11:0] TAI_OFS_I0_IE  = 12'h008;
  localparam logic [11:0] TAI_OFS_I0_IFG = 12'h00c;
  localparam logic [11:0] TAI_OFS_I1_IE  = 12'h010;
  localparam logic [11:0] TAI_OFS_I1_IFG = 12'h014;
  localparam logic [11:0] TAI_OFS_EVT_ST = 12'h018;
  localparam logic [11:0] TAI_OFS_EVT_CLR = 12'h01c;

  localparam int TAI_ADDR_W   = 10;
  localparam int TAI_BIT_NACK = 3;
  localparam int TAI_BIT_STOP = 2;
  localparam int TAI_BIT_STRT = 1;
  localparam int TAI_BIT_ARBL = 0;
  localparam int TAI_BIT_TX   = 3;
  localparam int TAI_BIT_RX   = 2;

  localparam logic [9:0] TAI_RST_TADDR = 10'h000;
  localparam logic [3:0] TAI_RST_EVT_IE = 4'h0;
  localparam logic [1:0] TAI_RST_INST_IE = 2'h0;
  localparam logic [3:0] TAI_RST_EVT_ST = 4'h0;
  localparam logic [31:0] TAI_RST_PRDATA = 32'h00000000;
  localparam int TAI_INST_N = 2;
  // Transmit flag high, receive flag low after reset.
  localparam logic [1:0] TAI_RST_INST_IFG = 2'h2;

  // Per-instance buffer events from the controller core.
  typedef struct packed {
    logic tx_empty;
    logic rx_full;
  } tai_buf_evt_t;

  // Bus events from the controller core, bit order as the enable layout.
  typedef struct packed {
    logic nack;
    logic stop;
    logic start;
    logic arb_lost;
  } tai_bus_evt_t;

endpackage

// file: tai_regs.sv
// Target address, event enables and per-instance flag registers on APB.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
module tai_regs
  import tai_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // Controller core status
  input  wire logic         master_mode,
  input  wire logic         addr_10bit,
  input  wire tai_bus_evt_t bus_evt,
  input  wire tai_buf_evt_t inst0_evt,
  input  wire tai_buf_evt_t inst1_evt,
  // Outputs to the core and interrupt controller
  output logic [9:0]        target_addr,
  output logic              target_addr_valid,
  output logic              irq
);

  // Register state. Each instance pair is packed as {tx, rx}.
  logic [9:0]      target_address_field_ff;
  logic [3:0]      evt_ie_ff;
  logic [31:0]     prdata_ff;

  // Register outputs gathered from the per-bit and per-instance blocks.
  wire [3:0]       evt_st_q;
  wire [1:0][1:0]  inst_ie_q;
  wire [1:0][1:0]  inst_ifg_q;

  // Next-state values of the shared registers.
  wire [9:0]       nxt_target_address_field;
  wire [3:0]       nxt_evt_ie;
  wire [31:0]      nxt_prdata;

  // Compares a bus address against one register offset.
  function automatic logic addr_hit(
    input logic [11:0] addr,
    input logic [11:0] ofs
  );
    return addr == ofs;
  endfunction

  // Places an instance pair at its bit positions in a data word.
  function automatic logic [7:0] inst_byte(input logic [1:0] v);
    logic [7:0] b;
    b = 8'h00;
    b[TAI_BIT_TX] = v[1];
    b[TAI_BIT_RX] = v[0];
    return b;
  endfunction

  // Pulls an instance pair out of a write data word.
  function automatic logic [1:0] inst_pick(input logic [31:0] d);
    return {d[TAI_BIT_TX], d[TAI_BIT_RX]};
  endfunction

  // Bus phases. Read data is captured in the setup cycle, so that it
  // stands through the whole access phase and no wait state is needed.
  wire setup_ph = psel & ~penable;
  wire access   = psel & penable;
  wire wr_en    = access & pwrite;
  wire rd_setup = setup_ph & ~pwrite;

  // Register selects for the shared registers.
  wire hit_ta  = addr_hit(paddr, TAI_OFS_TADDR);
  wire hit_eie = addr_hit(paddr, TAI_OFS_EVT_IE);
  wire hit_est = addr_hit(paddr, TAI_OFS_EVT_ST);
  wire hit_ecl = addr_hit(paddr, TAI_OFS_EVT_CLR);

  // Write strobes for the shared registers.
  wire wr_ta  = wr_en & hit_ta;
  wire wr_eie = wr_en & hit_eie;
  wire wr_ecl = wr_en & hit_ecl;

  // Write data split into the fields that the registers keep.
  wire [9:0] wd_taddr = pwdata[TAI_ADDR_W-1:0];
  wire [3:0] wd_evt   = pwdata[3:0];
  wire [1:0] wd_inst  = inst_pick(pwdata);

  // Per-instance selects and set events.
  wire [1:0] inst_hit_ie;
  wire [1:0] inst_hit_if;
  wire [3:0] inst_set_bus = {inst1_evt, inst0_evt};

  genvar g;
  generate
    for (g = 0; g < TAI_INST_N; g = g + 1) begin : g_inst
      localparam logic [11:0] OFS_IE  = (g == 0) ? TAI_OFS_I0_IE : TAI_OFS_I1_IE;
      localparam logic [11:0] OFS_IFG = (g == 0) ? TAI_OFS_I0_IFG : TAI_OFS_I1_IFG;

      logic [1:0] ie_ff;
      logic [1:0] ifg_ff;
      wire  [1:0] set_now = inst_set_bus[2*g +: 2];
      wire        wr_ie   = wr_en & inst_hit_ie[g];
      wire        wr_if   = wr_en & inst_hit_if[g];

      assign inst_hit_ie[g] = addr_hit(paddr, OFS_IE);
      assign inst_hit_if[g] = addr_hit(paddr, OFS_IFG);

      // R07 instance enables
      wire [1:0] nxt_ie = wr_ie ? wd_inst : ie_ff;

      // R08 flag set wins
      // Software may clear a flag, but a buffer event in the same cycle
      // keeps it set, so no event is lost to a late clear.
      wire [1:0] nxt_ifg = (wr_if ? wd_inst : ifg_ff) | set_now;

      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          ie_ff  <= TAI_RST_INST_IE;
          ifg_ff <= TAI_RST_INST_IFG;
        end else begin
          ie_ff  <= nxt_ie;
          ifg_ff <= nxt_ifg;
        end
      end

      assign inst_ie_q[g]  = ie_ff;
      assign inst_ifg_q[g] = ifg_ff;
    end
  endgenerate

  // Sticky bus event status, one flop per event.
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_evt
      logic st_ff;

      // Write-one-to-clear; an event in the same cycle as its clear stays set.
      wire clr_now = wr_ecl & wd_evt[g];
      wire nxt_st  = (st_ff & ~clr_now) | bus_evt[g];

      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          st_ff <= TAI_RST_EVT_ST[g];
        end else begin
          st_ff <= nxt_st;
        end
      end

      assign evt_st_q[g] = st_ff;
    end
  endgenerate

  // Named fields of the enable and flag registers.
  wire nack_irq_enable       = evt_ie_ff[TAI_BIT_NACK];
  wire stop_cond_irq_enable  = evt_ie_ff[TAI_BIT_STOP];
  wire start_cond_irq_enable = evt_ie_ff[TAI_BIT_STRT];
  wire arb_lost_irq_enable   = evt_ie_ff[TAI_BIT_ARBL];
  wire inst0_tx_irq_enable   = inst_ie_q[0][1];
  wire inst0_rx_irq_enable   = inst_ie_q[0][0];
  wire inst1_tx_irq_enable   = inst_ie_q[1][1];
  wire inst1_rx_irq_enable   = inst_ie_q[1][0];
  wire inst0_tx_flag         = inst_ifg_q[0][1];
  wire inst0_rx_flag         = inst_ifg_q[0][0];
  wire inst1_tx_flag         = inst_ifg_q[1][1];
  wire inst1_rx_flag         = inst_ifg_q[1][0];

  // Every access ends in one cycle; unmapped addresses answer with an error.
  wire mapped = hit_ta | hit_eie | hit_est | hit_ecl | (|inst_hit_ie) | (|inst_hit_if);

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_ff;

  // R01 ten-bit field
  // R02 right-justified
  assign nxt_target_address_field = wr_ta ? wd_taddr : target_address_field_ff;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      target_address_field_ff <= TAI_RST_TADDR;
    end else begin
      target_address_field_ff <= nxt_target_address_field;
    end
  end

  // R06 event enables
  assign nxt_evt_ie = wr_eie ? wd_evt : evt_ie_ff;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_ie_ff <= TAI_RST_EVT_IE;
    end else begin
      evt_ie_ff <= nxt_evt_ie;
    end
  end

  // Read words per register; reserved bits read as zero.
  wire [31:0] rd_taddr  = {22'h000000, target_address_field_ff};
  wire [31:0] rd_evt_ie = {28'h0000000, evt_ie_ff};
  wire [31:0] rd_evt_st = {28'h0000000, evt_st_q};
  wire [31:0] rd_i0_ie  = {24'h000000, inst_byte(inst_ie_q[0])};
  wire [31:0] rd_i0_ifg = {24'h000000, inst_byte(inst_ifg_q[0])};
  wire [31:0] rd_i1_ie  = {24'h000000, inst_byte(inst_ie_q[1])};
  wire [31:0] rd_i1_ifg = {24'h000000, inst_byte(inst_ifg_q[1])};

  // The clear register is write-only and reads as zero, like unmapped space.
  wire [31:0] rd_mux =
      hit_ta         ? rd_taddr  :
      hit_eie        ? rd_evt_ie :
      inst_hit_ie[0] ? rd_i0_ie  :
      inst_hit_if[0] ? rd_i0_ifg :
      inst_hit_ie[1] ? rd_i1_ie  :
      inst_hit_if[1] ? rd_i1_ifg :
      hit_est        ? rd_evt_st : 32'h00000000;

  assign nxt_prdata = rd_setup ? rd_mux : prdata_ff;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_ff <= TAI_RST_PRDATA;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // R04 seven-bit mode
  wire [9:0] addr_7bit = {3'h0, target_address_field_ff[6:0]};

  // R05 ten-bit mode
  wire [9:0] addr_full = target_address_field_ff;

  wire [9:0] addr_sel = addr_10bit ? addr_full : addr_7bit;

  // R03 master only
  // The core sees zero while it acts as a target, so a stale target
  // address can never leak into its own-address matching.
  assign target_addr       = master_mode ? addr_sel : 10'h000;
  assign target_addr_valid = master_mode;

  // R08 enabled flags only
  wire evt_irq = (evt_st_q[TAI_BIT_NACK] & nack_irq_enable)
               | (evt_st_q[TAI_BIT_STOP] & stop_cond_irq_enable)
               | (evt_st_q[TAI_BIT_STRT] & start_cond_irq_enable)
               | (evt_st_q[TAI_BIT_ARBL] & arb_lost_irq_enable);
  wire inst0_irq = (inst0_tx_flag & inst0_tx_irq_enable)
                 | (inst0_rx_flag & inst0_rx_irq_enable);
  wire inst1_irq = (inst1_tx_flag & inst1_tx_irq_enable)
                 | (inst1_rx_flag & inst1_rx_irq_enable);

  // A level output: it stays high until software clears the flag or the
  // enable, so a slow interrupt controller cannot miss it.
  assign irq = evt_irq | inst0_irq | inst1_irq;

endmodule

// file: tai_regs_assertions.sv
// Port assertions for the target address and interrupt registers.
`timescale 1ns/100ps
module tai_regs_chk (input wire logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr,
  input wire logic irq, master_mode, addr_10bit, target_addr_valid, input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, input wire logic [9:0] target_addr);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire logic [9:0] wd = pwdata[9:0];
  wire logic wr = psel && penable && pwrite && paddr == 12'h000 && master_mode;
  AST_VLD: assert property (target_addr_valid == master_mode) else $error("vld");
  AST_IGN: assert property (!master_mode |-> target_addr == 10'h000) else $error("ign");
  AST_HI: assert property (!addr_10bit |-> target_addr[9:7] == 3'h0) else $error("hi");
  AST_A7: assert property (wr && !addr_10bit |=>
    target_addr == ($past(wd) & 10'h07f)) else $error("a7");
  AST_A10: assert property (wr && addr_10bit |=>
    target_addr == $past(wd)) else $error("a10");
  AST_RDY: assert property (psel |-> pready) else $error("rdy");
  AST_ERR: assert property (psel && penable && paddr > 12'h01c |-> pslverr) else $error("err");
  AST_RST: assert property ($fell(sys_rst) |-> (!irq) [*2]) else $error("rst");
  cover property (irq);
  cover property (pslverr);
  cover property (wr && addr_10bit);
endmodule
bind tai_regs tai_regs_chk i_chk (.*);

// file: tai_core_model.sv
// Controller core stand-in that pulses bus and buffer events on request.
`timescale 1ns/100ps
module tai_core_model import tai_pkg::*; (input wire logic ref_clk, input wire logic [7:0] fire,
  output tai_bus_evt_t bus_evt, output tai_buf_evt_t inst0_evt, inst1_evt);
  always_ff @(posedge ref_clk) {inst1_evt, inst0_evt, bus_evt} <= fire;
endmodule

// file: tb.sv
// Self-checking bench for the target address and interrupt registers.
`timescale 1ns/100ps
module tb;
  logic ref_clk = '0, sys_rst = '1, psel = '0, penable = '0, pwrite = '0, pready, pslverr;
  logic master_mode = '0, addr_10bit = '0, target_addr_valid, irq, err;
  logic [11:0] paddr = '0, a;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [9:0] target_addr;
  logic [7:0] fire = '0;
  logic [3:0] bus_evt;
  logic [1:0] inst0_evt, inst1_evt;
  int n_errors = 0, checks = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  tai_core_model i_core (.*);
  tai_regs i_dut (.*);
  task automatic chk(input logic [32:0] got, exp);
    checks++;
    if (got !== exp) n_errors++;
    if (got !== exp) $display("mismatch at %0t: %h not %h", $time, got, exp);
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge ref_clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
    @(posedge ref_clk) penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    {err, rd} = {pslverr, prdata};
    {psel, penable} <= 2'h0;
    @(negedge ref_clk);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk({err, rd}, i == 8 ? 33'h100000000 : i == 3 || i == 5 ? 33'h8 : 33'h0);
    end
    $display("reset test done");
  endtask
  task automatic t_addr;
    @(posedge ref_clk) master_mode <= 1'b1;
    apb(1'b1, 12'h000, 32'hffff_fd55);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 33'h155);
    chk(target_addr, 33'h055);
    @(posedge ref_clk) addr_10bit <= 1'b1;
    @(negedge ref_clk) chk(target_addr, 33'h155);
    apb(1'b1, 12'h000, 32'h2aa);
    chk(target_addr, 33'h2aa);
    @(posedge ref_clk) master_mode <= 1'b0;
    @(negedge ref_clk) chk({target_addr_valid, target_addr}, 33'h0);
    $display("address test done");
  endtask
  task automatic t_irq;
    for (int k = 0; k < 6; k++) begin
      a = k < 4 ? 12'h004 : 12'(8 * k - 24);
      @(posedge ref_clk) fire <= 8'(1 << (k < 4 ? k : 2 * k - 4));
      repeat (3) @(posedge ref_clk) fire <= 8'h00;
      chk(irq, 33'h0);
      if (k < 4) apb(1'b0, 12'h018, 32'h0);
      if (k < 4) chk(rd, 33'(1 << k));
      apb(1'b1, a, k < 4 ? 32'(1 << k) : 32'h4);
      chk(irq, 33'h1);
      apb(1'b1, k < 4 ? 12'h01c : a + 12'h004, k < 4 ? 32'hf : 32'h0);
    end
    $display("irq test done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) if (++cyc == 4000) begin
    n_errors++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_addr();
    t_irq();
    conclude();
  end
endmodule
